// >>> hw/an_regs_defines.svh
`ifndef AN_REGS_DEFINES_SVH
`define AN_REGS_DEFINES_SVH

// register offsets on the management port
`define AN_ADDR_W        5
`define OFS_ADVERT       5'h04
`define OFS_PARTNER      5'h05
`define OFS_EXPAND       5'h06
`define OFS_IRQ_STAT     5'h1A
`define OFS_IRQ_MASK     5'h1B

// advertisement layout and reset values
`define ADV_TEN_BIT      5
`define ADV_WR_MASK      16'hADFF
`define ADV_UPPER_RESET  10'h000
`define SEL_RESET        5'h01

// partner base page layout
`define PB_NP_BIT        15
`define PB_RSV_BIT       12
`define PB_RESET         16'h0000

// expansion layout
`define EX_LOC_BIT       6
`define EX_STOR_BIT      5
`define EX_PDF_BIT       4
`define EX_LPNP_BIT      3
`define EX_NP_BIT        2
`define EX_PRX_BIT       1
`define EX_LPAN_BIT      0

// interrupt status and mask layout
`define IRQ_W            3
`define IRQ_PAGE_BIT     0
`define IRQ_PDF_BIT      1
`define IRQ_CHG_BIT      2
`define IRQ_RESET        3'h0

`endif

// >>> hw/an_regs_pkg.sv
package an_regs_pkg;

   typedef struct packed {
      logic       next_page_request;
      logic       ack;
      logic       remote_fault_flag;
      logic       reserved;
      logic       asymmetric_pause_ability;
      logic       pause_ability;
      logic       four_pair_fast_ability;
      logic       fast_full_duplex_ability;
      logic       fast_ability;
      logic       ten_meg_full_duplex_ability;
      logic       ten_meg_ability;
      logic [4:0] selector;
   } partner_page_t;

   typedef struct packed {
      logic [4:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   typedef struct packed {
      logic valid;
      logic is_next;
      partner_page_t word;
   } rx_page_t;

   typedef enum logic [1:0] {
      ST_IDLE     = 2'b00,
      ST_RECEIVED = 2'b01,
      ST_COMPLETE = 2'b10
   } neg_phase_t;

endpackage

// >>> hw/sticky_flag.sv
`timescale 1ns/100ps
// one status flag: an event sets it, a clear request drops it, set wins
module sticky_flag (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // control
   input  wire logic set,
   input  wire logic clear,
   // state
   output logic      flag_q
);
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
      end else if (set) begin
         flag_q <= 1'b1;
      end else if (clear) begin
         flag_q <= 1'b0;
      end
   end
endmodule

// >>> hw/autoneg_ability_status_regs.sv
// What this block does
// [RQ1] advertisement bit 5 read-write, reset value caught from a strap, advertises 10 Mb/s half
// [RQ2] advertisement bits 4:0 read-write protocol selector, reset 0 0001
// [RQ3] partner ability register loads received base page abilities
// [RQ4] partner bit 15 read-only: partner requests next pages, reset 0
// [RQ5] partner bit 14 read-only: partner acknowledged, taken from received bursts
// [RQ6] partner bit 13 read-only remote fault; bit 12 reads zero
// [RQ7] partner bits 11 and 10: asymmetric and symmetric pause, reset 0
// [RQ8] partner bits 9 to 5: technology abilities, read-only, reset 0
// [RQ9] partner bits 4:0 read-only received selector, reset 0 0000
// [RQ10] expansion bits 15:7 ignore writes and read zero
// [RQ11] expansion bits 6 and 5 read as one
// [RQ12] expansion bit 4 set on parallel detection fault, else zero
// [RQ13] expansion bit 3 shows partner next-page support, reset 0
// [RQ14] expansion bit 2 reads a fixed one
// [RQ15] expansion bit 1 set on page received, cleared by reading the register
// [RQ16] expansion bit 0 shows partner negotiation support, reset 0
// [RQ17] software restarts negotiation after changing advertisement before completion
// [RQ18] registers reachable at listed offsets, full 16-bit words on read
`timescale 1ns/100ps
`include "an_regs_defines.svh"
module autoneg_ability_status_regs (
   // clock and reset
   input  wire logic                   clock,
   input  wire logic                   resetn,
   // management port
   input  wire an_regs_pkg::reg_req_t  reg_req,
   output logic [15:0]                 rdata,
   // strap
   input  wire logic                   ten_meg_strap,
   // negotiation engine, line side
   input  wire an_regs_pkg::rx_page_t  rx_page,
   input  wire logic                   partner_an_seen,
   input  wire logic                   parallel_fault,
   input  wire logic                   an_complete,
   input  wire logic                   an_restart,
   // towards the negotiation engine
   output logic [15:0]                 advert_word,
   output logic                        advert_changed_early,
   // interrupt
   output logic                        irq
);
   import an_regs_pkg::*;

   logic                rst_meta_q;
   logic                rst_sync_q;
   logic                strap_done_q;
   logic                ten_meg_ability_q;
   logic [4:0]          selector_q;
   logic [9:0]          advert_upper_q;
   partner_page_t       partner_q;
   logic                partner_extra_page_capable_q;
   logic                partner_negotiation_capable_q;
   logic                parallel_detect_fault_q;
   logic                page_received_q;
   logic [`IRQ_W-1:0]   irq_stat_q;
   logic [`IRQ_W-1:0]   irq_mask_q;
   logic [`IRQ_W-1:0]   irq_event;
   logic [`IRQ_W-1:0]   irq_clear;
   logic [15:0]         rdata_d;
   logic [15:0]         rdata_q;
   logic [15:0]         expansion;
   logic [15:0]         advert_full;
   logic                base_load;
   logic                wr_advert;
   logic                rd_expand;
   logic                wr_irq_stat;
   logic                wr_irq_mask;
   logic                early_q;
   neg_phase_t          phase_q;
   neg_phase_t          phase_d;

   // reset released through two flops so release is clean against the clock
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // register port decode
   assign wr_advert   = reg_req.wr && (reg_req.addr == `OFS_ADVERT);
   assign rd_expand   = reg_req.rd && (reg_req.addr == `OFS_EXPAND);
   assign wr_irq_stat = reg_req.wr && (reg_req.addr == `OFS_IRQ_STAT);
   assign wr_irq_mask = reg_req.wr && (reg_req.addr == `OFS_IRQ_MASK);

   // base page arrives: next pages go elsewhere and leave this register alone
   assign base_load = rx_page.valid && !rx_page.is_next;

   // strap is caught by the first clock after reset release, never by the reset itself
   // limitation: the strap is read once, so a later change of its level needs a reset
   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         strap_done_q <= 1'b0;
      end else begin
         strap_done_q <= 1'b1;
      end
   end

   // 10 Mb/s half-duplex advertisement bit
   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         ten_meg_ability_q <= 1'b0;
      end else if (!strap_done_q) begin
         ten_meg_ability_q <= ten_meg_strap; // see [RQ1]
      end else if (wr_advert) begin
         ten_meg_ability_q <= reg_req.wdata[`ADV_TEN_BIT]; // see [RQ1]
      end
   end

   // protocol selector
   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         selector_q <= `SEL_RESET; // see [RQ2]
      end else if (wr_advert) begin
         selector_q <= reg_req.wdata[4:0]; // see [RQ2]
      end
   end

   // upper advertisement bits kept for the full word; reserved ones masked out
   // the mask is cut to the ten bits held here so nothing is dropped unnoticed
   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         advert_upper_q <= `ADV_UPPER_RESET;
      end else if (wr_advert) begin
         advert_upper_q <= reg_req.wdata[15:6] & 10'(`ADV_WR_MASK >> 6);
      end
   end

   assign advert_full = {advert_upper_q, ten_meg_ability_q, selector_q};

   // word handed to the transmit side of negotiation, registered
   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         advert_word <= 16'h0000;
      end else begin
         advert_word <= advert_full;
      end
   end

   // negotiation phase, used to flag writes that need a restart
   always_comb begin
      phase_d = phase_q;
      case (phase_q)
         ST_IDLE: begin
            if (an_complete) begin
               phase_d = ST_COMPLETE;
            end else if (base_load) begin
               phase_d = ST_RECEIVED;
            end
         end
         ST_RECEIVED: begin
            if (an_complete) begin
               phase_d = ST_COMPLETE;
            end
         end
         ST_COMPLETE: begin
            if (!an_complete) begin
               phase_d = ST_IDLE;
            end
         end
         default: begin
            phase_d = ST_IDLE;
         end
      endcase
      if (an_restart) begin
         phase_d = ST_IDLE;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         phase_q <= ST_IDLE;
      end else begin
         phase_q <= phase_d;
      end
   end

   // a write before completion stays pending until software restarts
   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         early_q <= 1'b0;
      end else if (wr_advert && phase_q != ST_COMPLETE) begin
         early_q <= 1'b1; // see [RQ17]
      end else if (an_restart) begin
         early_q <= 1'b0; // see [RQ17]
      end
   end

   assign advert_changed_early = early_q;

   // partner base page: every field but reserved bit 12 loaded together from the received word
   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         partner_q <= `PB_RESET; // see [RQ4] see [RQ7] see [RQ8] see [RQ9]
      end else if (base_load) begin
         partner_q                   <= rx_page.word; // see [RQ3] see [RQ4] see [RQ7] see [RQ8] see [RQ9]
         partner_q.ack               <= rx_page.word.ack; // see [RQ5]
         partner_q.remote_fault_flag <= rx_page.word.remote_fault_flag; // see [RQ6]
         partner_q.reserved          <= 1'b0; // see [RQ6]
      end
   end

   // partner next-page support follows its latest base page
   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         partner_extra_page_capable_q <= 1'b0;
      end else if (base_load) begin
         partner_extra_page_capable_q <= rx_page.word.next_page_request; // see [RQ13]
      end
   end

   // partner negotiation ability: seen bursts or any base page proves it
   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         partner_negotiation_capable_q <= 1'b0;
      end else if (partner_an_seen || base_load) begin
         partner_negotiation_capable_q <= 1'b1; // see [RQ16]
      end else if (an_restart) begin
         partner_negotiation_capable_q <= 1'b0;
      end
   end

   // parallel detection fault holds until the next negotiation restart
   sticky_flag u_pdf (
      .clock  (clock),
      .rst_n  (rst_sync_q),
      .set    (parallel_fault), // see [RQ12]
      .clear  (an_restart),
      .flag_q (parallel_detect_fault_q)
   );

   // page received, cleared by reading; an arrival in the read cycle survives
   sticky_flag u_page_rx (
      .clock  (clock),
      .rst_n  (rst_sync_q),
      .set    (rx_page.valid), // see [RQ15]
      .clear  (rd_expand), // see [RQ15]
      .flag_q (page_received_q)
   );

   // expansion word: constant bits tied, upper bits zero
   always_comb begin
      expansion                = 16'h0000; // see [RQ10]
      expansion[`EX_LOC_BIT]   = 1'b1; // see [RQ11]
      expansion[`EX_STOR_BIT]  = 1'b1; // see [RQ11]
      expansion[`EX_PDF_BIT]   = parallel_detect_fault_q; // see [RQ12]
      expansion[`EX_LPNP_BIT]  = partner_extra_page_capable_q; // see [RQ13]
      expansion[`EX_NP_BIT]    = 1'b1; // see [RQ14]
      expansion[`EX_PRX_BIT]   = page_received_q; // see [RQ15]
      expansion[`EX_LPAN_BIT]  = partner_negotiation_capable_q; // see [RQ16]
   end

   // interrupt events
   always_comb begin
      irq_event                = '0;
      irq_event[`IRQ_PAGE_BIT] = rx_page.valid;
      irq_event[`IRQ_PDF_BIT]  = parallel_fault;
      // compare against what the register will hold: reserved bit 12 is forced low there,
      // so a received word with that bit set cannot raise a change on its own
      irq_event[`IRQ_CHG_BIT]  = base_load && ({rx_page.word[15:13], 1'b0, rx_page.word[11:0]} != partner_q);
   end

   assign irq_clear = wr_irq_stat ? reg_req.wdata[`IRQ_W-1:0] : '0;

   // one sticky status bit per event, write one to clear
   genvar gi;
   generate
      for (gi = 0; gi < `IRQ_W; gi++) begin : g_irq
         sticky_flag u_stat (
            .clock  (clock),
            .rst_n  (rst_sync_q),
            .set    (irq_event[gi]),
            .clear  (irq_clear[gi]),
            .flag_q (irq_stat_q[gi])
         );
      end
   endgenerate

   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         irq_mask_q <= `IRQ_RESET;
      end else if (wr_irq_mask) begin
         irq_mask_q <= reg_req.wdata[`IRQ_W-1:0];
      end
   end

   // level output, registered so it is clean for the interrupt controller
   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   // read mux; unmapped offsets answer zero
   always_comb begin
      rdata_d = 16'h0000;
      case (reg_req.addr)
         `OFS_ADVERT: begin
            rdata_d = advert_full; // see [RQ18]
         end
         `OFS_PARTNER: begin
            rdata_d = partner_q; // see [RQ18]
         end
         `OFS_EXPAND: begin
            rdata_d = expansion; // see [RQ18]
         end
         `OFS_IRQ_STAT: begin
            rdata_d = {13'h0000, irq_stat_q};
         end
         `OFS_IRQ_MASK: begin
            rdata_d = {13'h0000, irq_mask_q};
         end
         default: begin
            rdata_d = 16'h0000;
         end
      endcase
   end

   // read data stand in the cycle after the strobe only
   // zero outside the answer cycle keeps a stale word off the shared read path
   always_ff @(posedge clock or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         rdata_q <= 16'h0000;
      end else if (reg_req.rd) begin
         rdata_q <= rdata_d; // see [RQ18]
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   assign rdata = rdata_q;

endmodule

// >>> testbench/an_regs_props.sv
`timescale 1ns/100ps
module an_regs_props (
   // clock and reset
   input wire logic                  clock,
   input wire logic                  resetn,
   // watched ports
   input wire an_regs_pkg::reg_req_t reg_req,
   input wire logic [15:0]           rdata,
   input wire an_regs_pkg::rx_page_t rx_page,
   input wire logic                  partner_an_seen,
   input wire logic                  parallel_fault,
   input wire logic                  an_restart
);
   import an_regs_pkg::*;
   logic        rd4, rd5, rd6, bp;
   logic [15:0] adv_q;
   logic [15:0] pb_q;
   logic        adv_v_q;
   logic        prx_q;
   assign rd4 = reg_req.rd && reg_req.addr == 5'h04 && !reg_req.wr;
   assign rd5 = reg_req.rd && reg_req.addr == 5'h05 && !rx_page.valid;
   assign rd6 = reg_req.rd && reg_req.addr == 5'h06;
   assign bp = rx_page.valid && !rx_page.is_next;
   // reference copies kept from the rules, so reads may come any number of cycles later
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         adv_q   <= 16'h0000;
         adv_v_q <= 1'b0;
      end else if (reg_req.wr && reg_req.addr == 5'h04) begin
         adv_q   <= reg_req.wdata & 16'hADFF;
         adv_v_q <= 1'b1;
      end
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pb_q <= 16'h0000;
      end else if (bp) begin
         pb_q <= rx_page.word & 16'hEFFF;
      end
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         prx_q <= 1'b0;
      end else if (rx_page.valid) begin
         prx_q <= 1'b1;
      end else if (rd6) begin
         prx_q <= 1'b0;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   a_rdata_idle: assert property (!$past(reg_req.rd) |-> rdata == 16'h0000)
      else $error("read data without a read");
   a_exp_fixed: assert property (rd6 |=> rdata[15:7] == 9'h000 && rdata[6:5] == 2'b11 && rdata[2])
      else $error("expansion fixed bits wrong");
   a_pb_rsv: assert property (reg_req.rd && reg_req.addr == 5'h05 |=> !rdata[12])
      else $error("partner reserved bit set");
   a_pb_load: assert property (rd5 |=> rdata == $past(pb_q))
      else $error("partner word not loaded");
   a_lpnp_copy: assert property (rd6 |=> rdata[3] == $past(pb_q[15]))
      else $error("partner next page flag wrong");
   a_page_set: assert property (rd6 |=> rdata[1] == $past(prx_q))
      else $error("page received flag wrong");
   a_page_clear: assert property (rd6 && !rx_page.valid ##1 !rx_page.valid ##1 rd6 |=> !rdata[1])
      else $error("page received not cleared by read");
   a_pdf_set: assert property (parallel_fault && !an_restart ##1 !an_restart ##1 rd6 && !an_restart |=> rdata[4])
      else $error("parallel fault not reported");
   a_lpan_set: assert property (partner_an_seen && !an_restart ##1 !an_restart ##1 rd6 && !an_restart |=> rdata[0])
      else $error("partner negotiation not reported");
   a_adv_mask: assert property (rd4 && adv_v_q |=> rdata == $past(adv_q))
      else $error("advertisement readback wrong");
endmodule
bind autoneg_ability_status_regs an_regs_props props_u (.clock(clock), .resetn(resetn), .reg_req(reg_req),
   .rdata(rdata), .rx_page(rx_page), .partner_an_seen(partner_an_seen), .parallel_fault(parallel_fault),
   .an_restart(an_restart));

// >>> testbench/link_partner_model.sv
`timescale 1ns/100ps
module link_partner_model (
   // clock
   input wire logic              clock,
   // received words towards the block
   output an_regs_pkg::rx_page_t rx_page
);
   import an_regs_pkg::*;
   initial rx_page = '0;
   // each page valid for one cycle, then its inverted word with valid low, so a load without valid shows
   task automatic send(input logic [15:0] w, input logic nx);
      @(posedge clock);
      rx_page <= {1'b1, nx, w};
      @(posedge clock);
      rx_page <= {1'b0, ~nx, ~w};
   endtask
endmodule

// >>> testbench/autoneg_ability_status_regs_tb.sv
`timescale 1ns/100ps
module autoneg_ability_status_regs_tb;
   import an_regs_pkg::*;
   logic        clock = 1'b0;
   logic        resetn = 1'b0;
   reg_req_t    req = '0;
   logic [15:0] rdata, aw, w;
   rx_page_t    rxp;
   logic        ans = 1'b0, pf = 1'b0, cpl = 1'b0, rst = 1'b0, irq, ace;
   int          n_mismatch = 0, checked = 0, cyc = 0;
   logic [15:0] adv = 16'h0021, pb = 16'h0000, pq[$];
   logic        lpnp = 1'b0, lpan = 1'b0, parallel_detect_fault = 1'b0, prx = 1'b0, strap = 1'b1;
   always #50 clock = ~clock;
   autoneg_ability_status_regs dut_u (.clock(clock), .resetn(resetn), .reg_req(req), .rdata(rdata),
      .ten_meg_strap(strap), .rx_page(rxp), .partner_an_seen(ans), .parallel_fault(pf), .an_complete(cpl),
      .an_restart(rst), .advert_word(aw), .advert_changed_early(ace), .irq(irq));
   link_partner_model lp_u (.clock(clock), .rx_page(rxp));
   task automatic end_sim;
      if (n_mismatch == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk16(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      chk16({15'h0000, g}, {15'h0000, e});
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clock);
      req <= {a, d, 2'b10};
      @(posedge clock);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      @(posedge clock);
      req <= {a, 16'h0000, 2'b01};
      @(posedge clock);
      req.rd <= 1'b0;
      #1 chk16(rdata, e);
   endtask
   task automatic pulse(input logic [2:0] v);
      @(posedge clock);
      {ans, pf, rst} <= v;
      @(posedge clock);
      {ans, pf, rst} <= 3'b000;
   endtask
   function automatic logic [15:0] exv();
      return {9'h000, 2'b11, parallel_detect_fault, lpnp, 1'b1, prx, lpan};
   endfunction
   task automatic page(input logic [15:0] x, input logic nx);
      lp_u.send(x, nx);
      prx = 1'b1;
      if (!nx) begin
         pb = x & 16'hEFFF;
         lpnp = x[15];
         lpan = 1'b1;
      end
   endtask
   // a hang counts as a failure
   always @(posedge clock) begin
      cyc++;
      if (cyc > 3000) begin
         n_mismatch++;
         end_sim();
      end
   end
   initial begin
      void'($urandom(32'h564D));
      adv[5] = 1'($urandom);
      strap <= adv[5];
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      repeat (4) @(posedge clock);
      rd(5'h04, adv);
      rd(5'h05, 16'h0000);
      rd(5'h06, exv());
      rd(5'h1A, 16'h0000);
      rd(5'h1B, 16'h0000);
      rd(5'h1F, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         w = 16'($urandom);
         wr(5'h04, w);
         wr(5'h05, ~w);
         wr(5'h06, ~w);
         adv = w & 16'hADFF;
         rd(5'h04, adv);
         rd(5'h05, pb);
         rd(5'h06, exv());
         chk16(aw, adv);
      end
      chk1(ace, 1'b1);
      pulse(3'b001);
      rd(5'h04, adv);
      chk1(ace, 1'b0);
      @(posedge clock);
      cpl <= 1'b1;
      wr(5'h04, 16'hFFFF);
      adv = 16'hADFF;
      rd(5'h04, adv);
      chk1(ace, 1'b0);
      wr(5'h1B, 16'h0003);
      repeat (3) pq.push_back(16'($urandom));
      pq.push_back(16'hFFFF);
      pq.push_back(16'h0000);
      while (pq.size() > 0) begin
         page(pq.pop_front(), 1'b0);
         rd(5'h05, pb);
         chk1(irq, 1'b1);
         rd(5'h06, exv());
         prx = 1'b0;
         rd(5'h06, exv());
      end
      // page and partner-changed events both latched; parallel fault not yet seen
      rd(5'h1A, 16'h0005);
      // clearing status drops the interrupt
      wr(5'h1A, 16'h0007);
      rd(5'h1A, 16'h0000);
      chk1(irq, 1'b0);
      wr(5'h1B, 16'h0000);
      page(16'h1234, 1'b1);
      rd(5'h05, pb);
      rd(5'h1A, 16'h0001);
      chk1(irq, 1'b0);
      wr(5'h1B, 16'h0001);
      rd(5'h06, exv());
      prx = 1'b0;
      chk1(irq, 1'b1);
      wr(5'h1A, 16'h0001);
      pulse(3'b110);
      parallel_detect_fault = 1'b1;
      lpan = 1'b1;
      rd(5'h06, exv());
      rd(5'h1A, 16'h0002);
      pulse(3'b001);
      parallel_detect_fault = 1'b0;
      lpan = 1'b0;
      rd(5'h06, exv());
      // second reset mid-run: the other strap level, all partner state back to zero
      @(posedge clock);
      resetn <= 1'b0;
      adv = {10'h000, ~strap, 5'h01};
      strap <= ~strap;
      cpl <= 1'b0;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      repeat (4) @(posedge clock);
      lpnp = 1'b0;
      pb = 16'h0000;
      rd(5'h04, adv);
      rd(5'h05, pb);
      rd(5'h06, exv());
      end_sim();
   end
endmodule
